// >>> sce_defines.vh
`ifndef SCE_DEFINES_VH
`define SCE_DEFINES_VH

// =============================================================
// Register addresses
`define SCE_REG_PC        4'h0
`define SCE_REG_ACC       4'h1
`define SCE_REG_MUL       4'h4
`define SCE_REG_IDX       4'h5
`define SCE_REG_SHX       4'h6

// =============================================================
// Operation codes (upper nibble)
`define SCE_OP_LOAD_IMM   4'h0
`define SCE_OP_CLEAR      4'h1
`define SCE_OP_AND        4'h2
`define SCE_OP_OR         4'h3
`define SCE_OP_ADD        4'h4
`define SCE_OP_STORE      4'h5
`define SCE_OP_SHL        4'h6
`define SCE_OP_SHR        4'h7
`define SCE_OP_INC        4'h8
`define SCE_OP_DEC        4'h9
`define SCE_OP_INV        4'hA
`define SCE_OP_BRANCH     4'hB

// =============================================================
// Fields and constants
`define SCE_OPC_MSB       7
`define SCE_OPC_LSB       4
`define SCE_SEL_MSB       3
`define SCE_SEL_LSB       0
`define SCE_SIGN_BIT      15
`define SCE_WORD_ZERO     16'h0000
`define SCE_BYTE_ZERO     8'h00
`define SCE_SEL_ZERO      4'h0
`define SCE_WORD_ONE      16'h0001
`define SCE_WORD_THREE    16'h0003
`define SCE_EXT_OP_FIRST  4'hC

`endif

// >>> sce_execute.v
// Operation
// - Each byte splits into upper opcode nibble and lower register selector.
// - Register 0 is the program counter addressing the next fetch byte.
// - Register 1 is the accumulator for two-operand and store ops.
// - Register 5 is the index register tested by branches.
// - Load immediate takes high then low byte; counter advances three unless register 0 is loaded.
// - The selector may name any of the sixteen registers.
// - Clear sets the selected register to zero in one cycle.
// - AND puts accumulator AND selected register into the accumulator.
// - OR puts accumulator OR selected register into the accumulator.
// - Add keeps low sixteen bits of the sum, carry discarded.
// - Store copies the accumulator into the selected register.
// - Left shift drops bit 15 and inserts zero at bit 0, except for register 6.
// - Left shift of register 6 fills bit 0 from register 4 MSB.
// - Right shift drops bit 0 and keeps bit 15, copying it down.
// - Increment adds one with silent wraparound.
// - Decrement subtracts one with silent wraparound.
// - Invert replaces the register with its bitwise complement.
// - Branch adds selected register to counter when index bit 15 clear.
// - Branch not taken when index bit 15 set; counter advances one.
// - After a taken branch the next fetch uses the new counter.
// - Single-byte instructions advance the counter by one, except taken branches, writes to register 0 and extension ops.
// - All registers other than destination and counter stay unchanged.
`timescale 1ns/1ps
`include "sce_defines.vh"
`default_nettype none

module sce_execute #(
    parameter DATA_W = 16,
    parameter NREGS  = 16
) (
    input  wire              CLK_I,
    input  wire              RST_I,
    input  wire [7:0]        FETCH_DATA_I,
    input  wire              FETCH_VALID_I,
    input  wire              EXT_DONE_I,
    input  wire [DATA_W-1:0] EXT_WDATA_I,
    input  wire [3:0]        EXT_WSEL_I,
    input  wire              EXT_WEN_I,
    input  wire              EXT_PC_NEXT_I,
    output reg  [DATA_W-1:0] FETCH_ADDR_O,
    output reg               FETCH_REQ_O,
    output reg               EXT_START_O,
    output reg  [7:0]        EXT_OPCODE_O,
    output reg  [DATA_W-1:0] EXT_ACC_O,
    output reg  [DATA_W-1:0] EXT_SELREG_O,
    output reg  [DATA_W-1:0] ACC_O,
    output reg  [DATA_W-1:0] PC_O
);

// =============================================================
// State machine
localparam [4:0] ST_FETCH = 5'b00001;
localparam [4:0] ST_HIGH  = 5'b00010;
localparam [4:0] ST_LOW   = 5'b00100;
localparam [4:0] ST_EXT   = 5'b01000;
localparam [4:0] ST_IDLE  = 5'b10000;

reg [4:0]        state;
reg [4:0]        next_state;
reg [DATA_W-1:0] regs [0:NREGS-1];
reg [3:0]        sel;
reg [7:0]        imm_high;

reg [DATA_W-1:0] next_wdata;
reg [3:0]        next_wsel;
reg              next_wen;
reg [DATA_W-1:0] next_pc;
reg              next_ext_start;
reg [7:0]        next_ext_op;

wire [3:0] opc = FETCH_DATA_I[`SCE_OPC_MSB:`SCE_OPC_LSB];
wire [3:0] fsel = FETCH_DATA_I[`SCE_SEL_MSB:`SCE_SEL_LSB];
wire [DATA_W-1:0] pc   = regs[`SCE_REG_PC];
wire [DATA_W-1:0] acc  = regs[`SCE_REG_ACC];
wire [DATA_W-1:0] idx  = regs[`SCE_REG_IDX];
wire [DATA_W-1:0] xval = regs[fsel];
wire [DATA_W-1:0] pc1  = pc + `SCE_WORD_ONE;

// Register 6 shift carry-in, decoded once per shift
function shl_fill;
    input [3:0]        s;
    input [DATA_W-1:0] mreg;
    begin
        if (s == `SCE_REG_SHX) begin
            shl_fill = mreg[`SCE_SIGN_BIT];
        end else begin
            shl_fill = 1'b0;
        end
    end
endfunction

// =============================================================
// Execute decode
always @* begin
    next_state     = state;
    next_wdata     = `SCE_WORD_ZERO;
    next_wsel      = `SCE_REG_ACC;
    next_wen       = 1'b0;
    next_pc        = pc;
    next_ext_start = 1'b0;
    next_ext_op    = EXT_OPCODE_O;
    case (state)
        ST_FETCH: begin
            if (FETCH_VALID_I) begin
                next_pc  = pc1;
                next_wen = 1'b1;
                next_wsel = fsel;
                case (opc)
                    `SCE_OP_LOAD_IMM: begin
                        next_wen   = 1'b0;
                        next_state = ST_HIGH;
                    end
                    `SCE_OP_CLEAR: begin
                        next_wdata = `SCE_WORD_ZERO;
                    end
                    `SCE_OP_AND: begin
                        next_wsel  = `SCE_REG_ACC;
                        next_wdata = acc & xval;
                    end
                    `SCE_OP_OR: begin
                        next_wsel  = `SCE_REG_ACC;
                        next_wdata = acc | xval;
                    end
                    `SCE_OP_ADD: begin
                        next_wsel  = `SCE_REG_ACC;
                        next_wdata = acc + xval;
                    end
                    `SCE_OP_STORE: begin
                        next_wdata = acc;
                    end
                    `SCE_OP_SHL: begin
                        next_wdata = {xval[DATA_W-2:0],
                                      shl_fill(fsel, regs[`SCE_REG_MUL])};
                    end
                    `SCE_OP_SHR: begin
                        next_wdata = {xval[DATA_W-1],
                                      xval[DATA_W-1:1]};
                    end
                    `SCE_OP_INC: begin
                        next_wdata = xval + `SCE_WORD_ONE;
                    end
                    `SCE_OP_DEC: begin
                        next_wdata = xval - `SCE_WORD_ONE;
                    end
                    `SCE_OP_INV: begin
                        next_wdata = ~xval;
                    end
                    `SCE_OP_BRANCH: begin
                        next_wen = 1'b0;
                        if (!idx[`SCE_SIGN_BIT]) begin
                            next_pc = pc + xval;
                        end else begin
                            next_pc = pc1;
                        end
                    end
                    default: begin
                        // Counter advance is left to the external unit
                        next_wen       = 1'b0;
                        next_pc        = pc;
                        next_ext_start = 1'b1;
                        next_ext_op    = FETCH_DATA_I;
                        next_state     = ST_EXT;
                    end
                endcase
            end
        end
        ST_HIGH: begin
            if (FETCH_VALID_I) begin
                next_pc    = pc1;
                next_state = ST_LOW;
            end
        end
        ST_LOW: begin
            if (FETCH_VALID_I) begin
                next_pc    = pc1;
                next_wen   = 1'b1;
                next_wsel  = sel;
                next_wdata = {imm_high, FETCH_DATA_I};
                next_state = ST_FETCH;
            end
        end
        ST_EXT: begin
            next_wen   = EXT_WEN_I;
            next_wsel  = EXT_WSEL_I;
            next_wdata = EXT_WDATA_I;
            if (EXT_DONE_I) begin
                if (EXT_PC_NEXT_I) begin
                    next_pc = pc1;
                end
                next_state = ST_FETCH;
            end
        end
        default: begin
            next_state = ST_FETCH;
        end
    endcase
end

// =============================================================
// Register file; only the named destination and the counter move
genvar gi;
generate
    for (gi = 0; gi < NREGS; gi = gi + 1) begin : g_reg
        always @(posedge CLK_I) begin
            if (RST_I) begin
                regs[gi] <= `SCE_WORD_ZERO;
            end else if (next_wen && next_wsel == gi
                         && gi != `SCE_REG_PC) begin
                regs[gi] <= next_wdata;
            end else if (gi == `SCE_REG_PC) begin
                // A write that targets the counter wins over advance
                if (next_wen && next_wsel == `SCE_REG_PC) begin
                    regs[gi] <= next_wdata;
                end else begin
                    regs[gi] <= next_pc;
                end
            end
        end
    end
endgenerate

// =============================================================
// Sequencing and outputs
always @(posedge CLK_I) begin
    if (RST_I) begin
        state        <= ST_FETCH;
        sel          <= `SCE_SEL_ZERO;
        imm_high     <= `SCE_BYTE_ZERO;
        EXT_START_O  <= 1'b0;
        EXT_OPCODE_O <= `SCE_BYTE_ZERO;
        EXT_ACC_O    <= `SCE_WORD_ZERO;
        EXT_SELREG_O <= `SCE_WORD_ZERO;
        FETCH_REQ_O  <= 1'b0;
        FETCH_ADDR_O <= `SCE_WORD_ZERO;
        ACC_O        <= `SCE_WORD_ZERO;
        PC_O         <= `SCE_WORD_ZERO;
    end else begin
        state       <= next_state;
        EXT_START_O <= next_ext_start;
        EXT_OPCODE_O <= next_ext_op;
        if (state == ST_FETCH && FETCH_VALID_I) begin
            sel          <= fsel;
            EXT_ACC_O    <= acc;
            EXT_SELREG_O <= xval;
        end
        if (state == ST_HIGH && FETCH_VALID_I) begin
            imm_high <= FETCH_DATA_I;
        end
        FETCH_REQ_O <= (next_state != ST_EXT);
        if (next_wen && next_wsel == `SCE_REG_PC) begin
            FETCH_ADDR_O <= next_wdata;
            PC_O         <= next_wdata;
        end else begin
            FETCH_ADDR_O <= next_pc;
            PC_O         <= next_pc;
        end
        if (next_wen && next_wsel == `SCE_REG_ACC) begin
            ACC_O <= next_wdata;
        end else begin
            ACC_O <= acc;
        end
    end
end

endmodule // sce_execute

`default_nettype wire

// >>> sce_execute_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sce_chk (
    input wire logic        CLK_I,
    input wire logic        RST_I,
    input wire logic [7:0]  FETCH_DATA_I,
    input wire logic        FETCH_VALID_I,
    input wire logic [15:0] FETCH_ADDR_O,
    input wire logic        FETCH_REQ_O,
    input wire logic        EXT_START_O,
    input wire logic [7:0]  EXT_OPCODE_O,
    input wire logic [15:0] ACC_O,
    input wire logic [15:0] PC_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // =========================================
    // Byte tracking
    // Immediate bytes must not be read as opcodes, so count them off
    logic [1:0] ld;
    logic [3:0] ld_sel;
    logic [7:0] hi;
    wire        tk  = FETCH_VALID_I && FETCH_REQ_O;
    wire        op  = tk && ld == 2'd0;
    wire  [3:0] opc = FETCH_DATA_I[7:4];
    wire  [3:0] sel = FETCH_DATA_I[3:0];
    always @(posedge CLK_I) begin
        if (RST_I) begin
            ld <= 2'd0;
        end else if (tk) begin
            ld <= (ld != 2'd0) ? ld - 2'd1 : ((opc == 4'h0) ? 2'd2 : 2'd0);
            ld_sel <= op ? sel : ld_sel;
            hi <= (ld == 2'd2) ? FETCH_DATA_I : hi;
        end
    end
    // =========================================
    // Properties
    sequence s_low_acc;
        tk && ld == 2'd1 && ld_sel == 4'h1;
    endsequence
    AST_LOAD_ACC: assert property (s_low_acc |=> ACC_O == {hi, $past(FETCH_DATA_I)})
        else $error("word load into accumulator wrong");
    AST_PC_MIRROR: assert property (PC_O == FETCH_ADDR_O)
        else $error("fetch address differs from counter");
    AST_START_ONE: assert property (EXT_START_O |=> !EXT_START_O)
        else $error("handover pulse too long");
    AST_HANDOVER: assert property (op && FETCH_DATA_I[7:6] == 2'b11 |=> EXT_START_O && !FETCH_REQ_O && EXT_OPCODE_O == $past(FETCH_DATA_I))
        else $error("upper opcode not handed over");
    AST_IDLE_HOLD: assert property (FETCH_REQ_O && !FETCH_VALID_I |=> $stable(PC_O) && $stable(ACC_O))
        else $error("state moved without a byte");
    AST_STEP_ONE: assert property (op && (opc inside {[4'h2:4'h4]} || (opc inside {[4'h1:4'hA]} && sel != 4'h0)) |=> PC_O == $past(PC_O) + 16'h0001)
        else $error("counter did not step by one");
    AST_CLEAR_ACC: assert property (op && FETCH_DATA_I == 8'h11 |=> ACC_O == 16'h0000)
        else $error("accumulator not cleared");
    AST_INC_ACC: assert property (op && FETCH_DATA_I == 8'h81 |=> ACC_O == $past(ACC_O) + 16'h0001)
        else $error("accumulator increment wrong");
endmodule // sce_chk
bind sce_execute sce_chk u_chk (.CLK_I(CLK_I), .RST_I(RST_I),
    .FETCH_DATA_I(FETCH_DATA_I), .FETCH_VALID_I(FETCH_VALID_I),
    .FETCH_ADDR_O(FETCH_ADDR_O), .FETCH_REQ_O(FETCH_REQ_O),
    .EXT_START_O(EXT_START_O), .EXT_OPCODE_O(EXT_OPCODE_O),
    .ACC_O(ACC_O), .PC_O(PC_O));
`default_nettype wire

// >>> sce_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module sce_flash (
    input  wire logic        clk_i,
    input  wire logic        en_i,
    input  wire logic        slow_i,
    input  wire logic [15:0] addr_i,
    output var  logic [7:0]  data_o,
    output var  logic        valid_o
);
    logic [7:0] mem [0:255];
    initial valid_o = 1'b0;
    // Off-cycle data is inverted so a byte taken without valid shows up
    always @* begin
        data_o = valid_o ? mem[addr_i[7:0]] : ~mem[addr_i[7:0]];
    end
    always @(posedge clk_i) begin
        valid_o <= en_i && !(slow_i && valid_o);
    end
endmodule // sce_flash
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
    fail_count++; $display("mismatch at %0t: %h vs %h", $time, a, b); \
    end end
module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        en = 1'b0;
    logic        slow = 1'b0;
    logic        ext_done = 1'b0;
    logic [31:0] ops_seen = 32'h0;
    logic [7:0]  prog [$];
    wire  [7:0]  data, ext_op;
    wire         valid, req, start;
    wire  [15:0] addr, acc, pc;
    wire  [15:0] ext_acc, ext_sel;
    logic [15:0] h_acc = 16'h0000;
    logic [15:0] h_sel = 16'h0000;
    int          fail_count = 0;
    int          n_compared = 0;
    initial forever #12.5 clk = ~clk;
    sce_flash FLASH (.clk_i(clk), .en_i(en), .slow_i(slow), .addr_i(addr),
        .data_o(data), .valid_o(valid));
    sce_execute DUT (.CLK_I(clk), .RST_I(rst), .FETCH_DATA_I(data),
        .FETCH_VALID_I(valid), .EXT_DONE_I(ext_done),
        .EXT_WDATA_I(16'h0000), .EXT_WSEL_I(4'h0), .EXT_WEN_I(1'b0),
        .EXT_PC_NEXT_I(1'b1), .FETCH_ADDR_O(addr), .FETCH_REQ_O(req),
        .EXT_START_O(start), .EXT_OPCODE_O(ext_op), .EXT_ACC_O(ext_acc),
        .EXT_SELREG_O(ext_sel), .ACC_O(acc), .PC_O(pc));
    // =========================================
    // Far-side unit: finishes one cycle after each handover
    always @(posedge clk) begin
        ext_done <= start;
        if (start) ops_seen <= {ops_seen[23:0], ext_op};
        if (start && ext_op == 8'hC3) begin
            h_acc <= ext_acc;
            h_sel <= ext_sel;
        end
    end
    // =========================================
    // Program runner; a branch by a zero register parks the counter
    task automatic run(input logic [15:0] halt);
        int i;
        rst <= 1'b1;
        en <= 1'b0;
        for (i = 0; i < 256; i++) FLASH.mem[i] = 8'h11;
        foreach (prog[j]) FLASH.mem[j] = prog[j];
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        en <= 1'b1;
        for (i = 0; i < 300 && pc !== halt; i++) @(posedge clk);
        repeat (6) @(posedge clk);
        #1;
        en <= 1'b0;
    endtask
    task automatic t_logic_add;
        prog = '{8'h01, 8'hF0, 8'hF0, 8'h02, 8'hFF, 8'h0F, 8'h22, 8'h03,
                 8'h0F, 8'h0F, 8'h33, 8'h04, 8'h00, 8'hF2, 8'h44, 8'hB7};
        run(16'h000F);
        `CHK(pc, 16'h000F)
        `CHK(acc, 16'h0001)
        $display("logic and add test done");
    endtask
    task automatic t_unary;
        prog = '{8'h01, 8'h80, 8'h01, 8'h56, 8'h54, 8'h66, 8'h57, 8'h67,
                 8'h58, 8'h78, 8'h99, 8'h89, 8'hAF, 8'h11, 8'h46, 8'h47,
                 8'h48, 8'h49, 8'h4F, 8'h44, 8'hBB};
        run(16'h0014);
        `CHK(pc, 16'h0014)
        `CHK(acc, 16'h4005)
        $display("unary test done");
    endtask
    task automatic t_branch;
        prog = '{8'h02, 8'h00, 8'h04, 8'hB2, 8'h81, 8'h81, 8'h81, 8'h81,
                 8'h05, 8'h80, 8'h00, 8'hB2, 8'h81, 8'h15, 8'hB3};
        run(16'h000E);
        `CHK(pc, 16'h000E)
        `CHK(acc, 16'h0002)
        $display("branch test done");
    endtask
    task automatic t_handover;
        slow <= 1'b1;
        prog = '{8'h01, 8'h12, 8'h34, 8'h03, 8'h00, 8'hA5, 8'hC3, 8'hD4,
                 8'hE5, 8'hF6, 8'h81, 8'hB2};
        run(16'h000B);
        `CHK(ops_seen, 32'hC3D4E5F6)
        `CHK(h_acc, 16'h1234)
        `CHK(h_sel, 16'h00A5)
        `CHK(acc, 16'h1235)
        slow <= 1'b0;
        $display("handover test done");
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        t_logic_add();
        t_unary();
        t_branch();
        t_handover();
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        stop_test();
    end
endmodule // tb
`default_nettype wire
